// ---- pqm_consts.svh ----
`ifndef PQM_CONSTS_SVH
`define PQM_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PQM_ADDR_MAP_LOW 8'h80
`define PQM_ADDR_MAP_HIGH 8'h81
`define PQM_ADDR_SPLIT 8'h82
`define PQM_ADDR_MODE 8'h90

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define PQM_RST_MAP_LOW 8'h50
`define PQM_RST_MAP_HIGH 8'hFA
`define PQM_RST_SPLIT 2'h2
`define PQM_SPLIT_LSB 6
// low six bits of the split register are read-only and keep this pattern
`define PQM_SPLIT_RSVD 6'h08
`define PQM_RST_MODE 1'h0
`define PQM_QUEUE_LOW 2'h0
`define PQM_QUEUE_HIGH 2'h3
`define PQM_TPID 16'h8100

`endif

// ---- pqm_pkg.sv ----
package pqm_pkg;
    typedef logic [1:0] pqm_queue_t;
    typedef logic [2:0] pqm_pcp_t;
    typedef logic [7:0] pqm_byte_t;
    typedef enum logic [1:0] {
        PQM_IDLE = 2'h0,
        PQM_MAPPED = 2'h1,
        PQM_DONE = 2'h3
    } pqm_state_t;
endpackage : pqm_pkg

// ---- pqm_split.sv ----
`timescale 1ns/100ps
`include "pqm_consts.svh"

module pqm_split (
    input wire logic [1:0] i_result,
    input wire logic [1:0] i_split,
    output logic o_high
);
    import pqm_pkg::*;
    always_comb begin
        case (i_result)
            2'h0: o_high = 1'h0;
            2'h1: o_high = i_split[0];
            2'h2: o_high = i_split[1];
            default: o_high = 1'h1;
        endcase
    end
endmodule : pqm_split

// ---- pqm_mapper.sv ----
`timescale 1ns/100ps
`include "pqm_consts.svh"
// Behaviour
// - each of eight priority codes maps to one of four queues via 2-bit entry
// - queue 3 is highest priority, queue 0 lowest
// - low map byte holds codes 0-3 at bits 1:0..7:6, reset 0,0,1,1
// - high map byte holds codes 4-7 at bits 1:0..7:6, reset 2,2,3,3
// - in two-queue mode a 2-bit result becomes low/high via split bits 7:6
// - result 0 low, result 3 high, split bit0 for 1, bit1 for 2
// - split 00: results 0-2 low; 10 (reset): 2-3 high; 11: 1-3 high

module pqm_mapper (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire pqm_pkg::pqm_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output pqm_pkg::pqm_byte_t o_rdata,
    input wire logic i_cls_valid,
    input wire logic [15:0] i_tag_tpid,
    input wire logic [15:0] i_tag_tci,
    input wire logic i_use_tos,
    input wire logic [1:0] i_tos_result,
    output logic o_cls_valid,
    output pqm_pkg::pqm_queue_t o_queue,
    output logic o_high
);
    import pqm_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        pqm_byte_t map_low;
        pqm_byte_t map_high;
        logic [1:0] split;
        logic two_q;
        pqm_byte_t rdata;
        logic valid;
        pqm_queue_t queue;
        logic high;
    } pqm_regs_t;

    // one decoder serves both strobes, so a read always shows exactly
    // the register that a write to the same address would change
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_MAP_LOW = 3'h1,
        SEL_MAP_HIGH = 3'h2,
        SEL_SPLIT = 3'h3,
        SEL_MODE = 3'h4
    } pqm_sel_t;

    pqm_regs_t st_r;
    pqm_regs_t st_nxt;
    logic [15:0] map_all;
    pqm_pcp_t pcp;
    pqm_queue_t result;
    logic split_high;
    pqm_sel_t sel;

    function automatic pqm_queue_t entry_of(input logic [15:0] m, input pqm_pcp_t p);
        entry_of = m[{p, 1'h0} +: 2];
    endfunction : entry_of

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic pqm_sel_t sel_of(input logic [7:0] a);
        if (a == `PQM_ADDR_MAP_LOW) begin
            sel_of = SEL_MAP_LOW;
        end else if (a == `PQM_ADDR_MAP_HIGH) begin
            sel_of = SEL_MAP_HIGH;
        end else if (a == `PQM_ADDR_SPLIT) begin
            sel_of = SEL_SPLIT;
        end else if (a == `PQM_ADDR_MODE) begin
            sel_of = SEL_MODE;
        end else begin
            sel_of = SEL_NONE;
        end
    endfunction : sel_of

    assign sel = sel_of(i_addr);

    assign map_all = {st_r.map_high, st_r.map_low};
    // untagged frames fall back to code 0
    assign pcp = (i_tag_tpid == `PQM_TPID) ? i_tag_tci[15:13] : 3'h0;
    assign result = i_use_tos ? i_tos_result : entry_of(map_all, pcp);

    pqm_split u_split (
        .i_result(result),
        .i_split(st_r.split),
        .o_high(split_high)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = i_cls_valid;
        if (i_cls_valid) begin
            // uses registered map, so a write lands before the next frame
            st_nxt.queue = result;
            st_nxt.high = st_r.two_q ? split_high : (result == `PQM_QUEUE_HIGH);
        end
        if (i_wr) begin
            if (sel == SEL_MAP_LOW) begin
                st_nxt.map_low = i_wdata;
            end else if (sel == SEL_MAP_HIGH) begin
                st_nxt.map_high = i_wdata;
            end else if (sel == SEL_SPLIT) begin
                // value 01 is stored as written; its mapping is undefined
                // the low six bits are read-only, so a write there is dropped
                st_nxt.split = i_wdata[`PQM_SPLIT_LSB +: 2];
            end else if (sel == SEL_MODE) begin
                // local mode bit; until it is set the split field has no effect
                st_nxt.two_q = i_wdata[0];
            end
        end
        st_nxt.rdata = 8'h00;
        if (i_rd) begin
            if (sel == SEL_MAP_LOW) begin
                st_nxt.rdata = st_r.map_low;
            end else if (sel == SEL_MAP_HIGH) begin
                st_nxt.rdata = st_r.map_high;
            end else if (sel == SEL_SPLIT) begin
                st_nxt.rdata = {st_r.split, `PQM_SPLIT_RSVD};
            end else if (sel == SEL_MODE) begin
                st_nxt.rdata = {7'h00, st_r.two_q};
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r.map_low <= `PQM_RST_MAP_LOW;
            st_r.map_high <= `PQM_RST_MAP_HIGH;
            st_r.split <= `PQM_RST_SPLIT;
            st_r.two_q <= `PQM_RST_MODE;
            st_r.rdata <= 8'h00;
            st_r.valid <= 1'h0;
            st_r.queue <= 2'h0;
            st_r.high <= 1'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_cls_valid = st_r.valid;
    assign o_queue = st_r.queue;
    assign o_high = st_r.high;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_queue_lookup: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && !i_use_tos |=> o_queue == $past(entry_of(map_all, pcp)))
        else $error("queue does not match map entry");
    chk_two_q_low: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && st_r.two_q && result == 2'h0 |=> !o_high)
        else $error("result 0 not low");
    chk_two_q_high: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && result == 2'h3 |=> o_high)
        else $error("result 3 not high");
    chk_split_mid: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && st_r.two_q && result == 2'h2 |=> o_high == $past(st_r.split[1]))
        else $error("result 2 split wrong");
    chk_split_one: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && st_r.two_q && result == 2'h1 |=> o_high == $past(st_r.split[0]))
        else $error("result 1 split wrong");
    chk_four_q_high: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && !st_r.two_q |=> o_high == (o_queue == 2'h3))
        else $error("four queue high flag wrong");
    chk_map_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_wr && i_addr == `PQM_ADDR_MAP_LOW |=> st_r.map_low == $past(i_wdata))
        else $error("low map not written");
    chk_map_high_wr: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_wr && i_addr == `PQM_ADDR_MAP_HIGH ##1 i_rd && i_addr == `PQM_ADDR_MAP_HIGH
        |=> o_rdata == $past(i_wdata, 2))
        else $error("high map readback wrong");
    chk_write_applies: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_wr && i_addr == `PQM_ADDR_MAP_LOW ##1 i_cls_valid && !i_use_tos
        && i_tag_tpid == `PQM_TPID && i_tag_tci[15:13] == 3'h0
        |=> o_queue == $past(i_wdata[1:0], 2))
        else $error("write not applied to next frame");

    // ----------------------------------------
    // register and classification checks
    // ----------------------------------------
    chk_map_low_rd: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_rd && i_addr == `PQM_ADDR_MAP_LOW |=> o_rdata == $past(st_r.map_low))
        else $error("low map readback wrong");
    chk_map_high_rd: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_rd && i_addr == `PQM_ADDR_MAP_HIGH |=> o_rdata == $past(st_r.map_high))
        else $error("high map read wrong");
    chk_split_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_wr && i_addr == `PQM_ADDR_SPLIT |=> st_r.split == $past(i_wdata[7:6]))
        else $error("split field not written");
    chk_split_rd: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_rd && i_addr == `PQM_ADDR_SPLIT |=> o_rdata == {$past(st_r.split), `PQM_SPLIT_RSVD})
        else $error("split register readback wrong");
    chk_tos_select: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && i_use_tos |=> o_queue == $past(i_tos_result))
        else $error("tos result not taken");
    chk_split_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && st_r.two_q && st_r.split == 2'h0 && result != 2'h3 |=> !o_high)
        else $error("split 00 gave high below result 3");
    chk_split_two: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && st_r.two_q && st_r.split == 2'h2 |=> o_high == ($past(result) >= 2'h2))
        else $error("split 10 grouping wrong");
    chk_split_three: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && st_r.two_q && st_r.split == 2'h3 && result != 2'h0 |=> o_high)
        else $error("split 11 gave low above result 0");
    chk_untagged_code: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid && !i_use_tos && i_tag_tpid != `PQM_TPID
        |=> o_queue == $past(st_r.map_low[1:0]))
        else $error("untagged frame not on code 0");
    chk_valid_pulse: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_cls_valid |=> o_cls_valid)
        else $error("classify answer missing");
    chk_queue_holds: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !i_cls_valid |=> !o_cls_valid && $stable(o_queue) && $stable(o_high))
        else $error("idle cycle changed the result");
endmodule : pqm_mapper

// ---- priority_queue_mapper_tb_top.sv ----
`timescale 1ns/100ps
`include "pqm_consts.svh"

module priority_queue_mapper_tb_top;
    import pqm_pkg::*;
    logic i_clock = 1'h0;
    logic i_resetn = 1'h0;
    logic [7:0] i_addr = 8'h00;
    pqm_byte_t i_wdata = 8'h00;
    logic i_wr = 1'h0;
    logic i_rd = 1'h0;
    logic i_cls_valid = 1'h0;
    logic [15:0] i_tag_tpid = 16'h0000;
    logic [15:0] i_tag_tci = 16'h0000;
    logic i_use_tos = 1'h0;
    logic [1:0] i_tos_result = 2'h0;
    pqm_byte_t o_rdata;
    logic o_cls_valid;
    pqm_queue_t o_queue;
    logic o_high;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] map;
    logic [1:0] sp;

    pqm_mapper dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cls_valid(i_cls_valid),
        .i_tag_tpid(i_tag_tpid), .i_tag_tci(i_tag_tci), .i_use_tos(i_use_tos),
        .i_tos_result(i_tos_result), .o_cls_valid(o_cls_valid), .o_queue(o_queue),
        .o_high(o_high));

    // ----------------------------------------
    // clock, hang guard and verdict
    // ----------------------------------------
    initial forever #20 i_clock = ~i_clock;

    // about 110 cycles of traffic; the ceiling leaves ample margin
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_clock);
        i_wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_clock);
        i_rd <= 1'h0;
        #1;
        chk(o_rdata, exp);
    endtask : rd

    // write and read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_clock);
        i_wr <= 1'h0;
        i_rd <= 1'h1;
        @(posedge i_clock);
        i_rd <= 1'h0;
        #1;
        chk(o_rdata, d);
    endtask : wr_rd

    task automatic cls_set(input logic [2:0] pcp, input logic [15:0] tpid, input logic ut,
        input logic [1:0] tr);
        i_cls_valid <= 1'h1;
        i_tag_tpid <= tpid;
        i_tag_tci <= {pcp, 13'h0000};
        i_use_tos <= ut;
        i_tos_result <= tr;
    endtask : cls_set

    task automatic cls_chk(input logic [1:0] eq, input logic eh);
        @(posedge i_clock);
        i_cls_valid <= 1'h0;
        #1;
        chk(o_cls_valid, 8'h01);
        chk(o_queue, eq);
        chk(o_high, eh);
    endtask : cls_chk

    task automatic cls(input logic [2:0] pcp, input logic [15:0] tpid, input logic ut,
        input logic [1:0] tr, input logic [1:0] eq, input logic eh);
        @(posedge i_clock);
        cls_set(pcp, tpid, ut, tr);
        cls_chk(eq, eh);
    endtask : cls

    // low map write followed at once by a frame that must see the new entry
    task automatic wr_cls(input logic [7:0] d, input logic [2:0] pcp, input logic [1:0] eq,
        input logic eh);
        @(posedge i_clock);
        i_addr <= `PQM_ADDR_MAP_LOW;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_clock);
        i_wr <= 1'h0;
        cls_set(pcp, `PQM_TPID, 1'h0, 2'h0);
        cls_chk(eq, eh);
    endtask : wr_cls

    // split result: 0 low, 3 high, 1 and 2 follow their split bit
    function automatic logic hi2(input logic [1:0] s, input logic [1:0] r);
        return (r == 2'h3) || (r == 2'h1 && s[0]) || (r == 2'h2 && s[1]);
    endfunction : hi2

    initial begin
        repeat (3) @(posedge i_clock);
        i_resetn <= 1'h1;
        rd(`PQM_ADDR_MAP_LOW, 8'h50);
        rd(`PQM_ADDR_MAP_HIGH, 8'hFA);
        rd(`PQM_ADDR_SPLIT, 8'h88);
        rd(`PQM_ADDR_MODE, 8'h00);
        rd(8'h83, 8'h00);
        map = 16'hFA50;
        for (int p = 0; p < 8; p++) begin
            cls(p[2:0], `PQM_TPID, 1'h0, 2'h0, map[2*p+:2], map[2*p+:2] == 2'h3);
        end
        cls(3'h0, `PQM_TPID, 1'h1, 2'h2, 2'h2, 1'h0);
        wr(`PQM_ADDR_MAP_LOW, 8'h1B);
        wr(`PQM_ADDR_MAP_HIGH, 8'hE4);
        map = 16'hE41B;
        for (int p = 0; p < 8; p++) begin
            cls(p[2:0], `PQM_TPID, 1'h0, 2'h0, map[2*p+:2], map[2*p+:2] == 2'h3);
        end
        wr(8'h83, 8'hFF);
        rd(8'h83, 8'h00);
        rd(`PQM_ADDR_MAP_LOW, 8'h1B);
        rd(`PQM_ADDR_MAP_HIGH, 8'hE4);
        cls(3'h7, 16'h0000, 1'h0, 2'h0, 2'h3, 1'h1);
        wr(`PQM_ADDR_MODE, 8'h01);
        rd(`PQM_ADDR_MODE, 8'h01);
        for (int k = 0; k < 3; k++) begin
            // split value 01 is never programmed
            sp = (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : 2'h3;
            wr(`PQM_ADDR_SPLIT, {sp, 6'h3F});
            rd(`PQM_ADDR_SPLIT, {sp, 6'h08});
            for (int r = 0; r < 4; r++) begin
                cls(3'h0, `PQM_TPID, 1'h1, r[1:0], r[1:0], hi2(sp, r[1:0]));
            end
        end
        cls(3'h5, `PQM_TPID, 1'h0, 2'h0, 2'h1, 1'h1);
        cls(3'h4, `PQM_TPID, 1'h0, 2'h0, 2'h0, 1'h0);
        wr_rd(`PQM_ADDR_MAP_HIGH, 8'hB1);
        wr_cls(8'h1E, 3'h0, 2'h2, 1'h1);
        results();
    end
endmodule : priority_queue_mapper_tb_top
